// *** shared/mdcs_pkg.sv ***
// constants, types and state layouts for the mixed decay chop sequencer
package mdcs_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_KHZ       = 40000;
  localparam int OSC_RATE_KHZ  = 920;
  localparam int OSC_DIV       = CLK_KHZ / OSC_RATE_KHZ;
  localparam int DIV_W         = 6;

  localparam int CHOP_CLKS = 16;
  localparam int PER_W     = 4;
  localparam logic [PER_W-1:0] PER_LAST = 4'hf;
  localparam logic [PER_W-1:0] PER_RST  = 4'h0;

  localparam int FAST_CLKS = 6;
  localparam int FAST_W    = 3;
  localparam logic [FAST_W-1:0] FAST_LAST = 3'h5;

  localparam int DEAD_NS  = 400;
  localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W   = 5;

  localparam int BLANK_NS  = 1000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W   = 6;

  localparam int VREF_W   = 13;
  localparam int ISENSE_W = 16;
  localparam int TRIP_W   = 17;
  localparam logic [TRIP_W-1:0] GAIN_NUM = 17'h00009;
  localparam int SINGLE_SHIFT = 2;
  localparam int DUAL_SHIFT   = 3;

  localparam logic [1:0] START_LAST = 2'h3;

  typedef enum logic [2:0] {
    PH_CHARGE = 3'b001,
    PH_FAST   = 3'b010,
    PH_SLOW   = 3'b100
  } mdcs_phase_t;

  typedef struct packed {
    logic in1;
    logic in2;
    logic pwm;
  } mdcs_ctrl_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } mdcs_gate_t;

  localparam mdcs_gate_t GATE_OFF = 2'b00;
  localparam mdcs_gate_t GATE_HI  = 2'b10;
  localparam mdcs_gate_t GATE_LO  = 2'b01;

  typedef struct packed {
    mdcs_gate_t        gate;
    logic [DEAD_W-1:0] cnt;
  } mdcs_leg_state_t;

  typedef struct packed {
    logic [1:0]                 start;
    logic                       mode_done;
    logic                       mode_single;
    logic                       bm_s1;
    logic                       bm_s2;
    mdcs_ctrl_t [1:0]           c_s1;
    mdcs_ctrl_t [1:0]           c_s2;
    mdcs_ctrl_t [1:0]           c_prev;
    logic [DIV_W-1:0]           div;
    logic [PER_W-1:0]           per;
    logic [1:0][2:0]            phase;
    logic [1:0][FAST_W-1:0]     fast;
    logic [1:0][BLANK_W-1:0]    blank;
    logic [1:0][TRIP_W-1:0]     trip;
  } mdcs_top_state_t;

endpackage

// *** rtl/mdcs_leg.sv ***
// one half-bridge leg with break-before-make dead time
`timescale 1ns/10ps
`default_nettype none
module mdcs_leg #(
  parameter int DEAD_CYC_P = mdcs_pkg::DEAD_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire mdcs_pkg::mdcs_gate_t want,
  output var  mdcs_pkg::mdcs_gate_t gate
);
  import mdcs_pkg::*;

  if (DEAD_CYC_P < 1 || DEAD_CYC_P > 2**DEAD_W) begin : bad_dead
    $error("dead time count out of range");
  end

  localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_CYC_P - 1);

  mdcs_leg_state_t st_reg;
  mdcs_leg_state_t st_next;
  logic [7:0]      off_run;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    if (want != st_reg.gate) begin
      if (st_reg.gate != GATE_OFF) begin
        st_next.gate = GATE_OFF;
        st_next.cnt  = DEAD_LOAD;
      end else if (st_reg.cnt == '0 && !(want.hi && want.lo)) begin
        st_next.gate = want;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gate = st_reg.gate;

  ////////////////////////////////////////////////////////////////////////////////
  // helper: length of the current all-off stretch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      off_run <= 8'hff;
    end else if (st_reg.gate != GATE_OFF) begin
      off_run <= 8'h00;
    end else if (off_run != 8'hff) begin
      off_run <= off_run + 8'h01;
    end
  end

  never_both_a: assert property (@(posedge clk) disable iff (!nrst)
    !(gate.hi && gate.lo))
    else $error("both transistors of a leg on");

  dead_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    ($past(gate) == GATE_OFF && gate != GATE_OFF) |-> $past(off_run) >= DEAD_CYC_P - 1)
    else $error("leg switched on before dead time elapsed");

  dead_apply_a: assert property (@(posedge clk) disable iff (!nrst)
    (gate == GATE_OFF && want != GATE_OFF && !(want.hi && want.lo)
     && off_run >= DEAD_CYC_P - 1) |=> gate == $past(want))
    else $error("leg not driven after dead time");

endmodule
`default_nettype wire

// *** rtl/mdcs_top.sv ***
// two-bridge mixed decay chopping sequencer with blanking and dead time
`timescale 1ns/10ps
`default_nettype none
// How it works
// - phases loop charge, fast decay, slow decay, charge, holding peak current at trip level
// - chopping period is sixteen internal oscillator clocks; phases switch inside it
// - charge until comparator reports trip level reached, then enter fast decay
// - fast decay lasts six oscillator clocks, then slow decay for the period remainder
// - trip with under six clocks left keeps fast decay until period end
// - every transistor change inserts 400 ns with both transistors of the leg off
// - trip level is vref times 2.25 single-bridge, 1.125 dual-bridge
// - control input transitions open a blanking window that masks the comparator
// - bridge mode high drives both bridges from first controls; latched at startup
module mdcs_top #(
  parameter int OSC_DIV_P   = mdcs_pkg::OSC_DIV,
  parameter int BLANK_CYC_P = mdcs_pkg::BLANK_CYC,
  parameter int DEAD_CYC_P  = mdcs_pkg::DEAD_CYC
) (
  input  wire logic                                     clk,
  input  wire logic                                     nrst,
  input  wire mdcs_pkg::mdcs_ctrl_t [1:0]               ctrl_pin,
  input  wire logic                                     bridge_mode_select,
  input  wire logic [1:0][mdcs_pkg::VREF_W-1:0]         vref_mv,
  input  wire logic [1:0][mdcs_pkg::ISENSE_W-1:0]       isense_ma,
  output var  mdcs_pkg::mdcs_gate_t [3:0]               gate,
  output logic [1:0][2:0]                               phase_out,
  output logic [1:0][mdcs_pkg::TRIP_W-1:0]              current_trip_level,
  output logic                                          bridge_mode_single
);
  import mdcs_pkg::*;

  if (OSC_DIV_P < 2 || OSC_DIV_P > 2**DIV_W) begin : bad_div
    $error("oscillator divider out of range");
  end
  if (BLANK_CYC_P < 1 || BLANK_CYC_P > 2**BLANK_W - 1) begin : bad_blank
    $error("blanking count out of range");
  end

  localparam logic [DIV_W-1:0]   DIV_LAST   = DIV_W'(OSC_DIV_P - 1);
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYC_P);

  mdcs_top_state_t  st_reg;
  mdcs_top_state_t  st_next;
  mdcs_gate_t [3:0] want;
  logic             tick;
  logic             per_end;
  logic [1:0]       run;
  logic [1:0]       trip_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    mdcs_ctrl_t            c;
    logic                  stby;
    logic                  act;
    logic [TRIP_W-1:0]     meas;
    logic [TRIP_W-1:0]     prod;
    logic [VREF_W-1:0]     vsel;
    int                    src;
    c       = '0;
    stby    = 1'b1;
    act     = 1'b0;
    meas    = '0;
    prod    = '0;
    vsel    = '0;
    src     = 0;
    st_next = st_reg;
    want    = '{default: GATE_OFF};
    run     = '0;
    trip_ok = '0;

    // pins pass two flops before use
    st_next.c_s1   = ctrl_pin;
    st_next.c_s2   = st_reg.c_s1;
    st_next.c_prev = st_reg.c_s2;
    st_next.bm_s1  = bridge_mode_select;
    st_next.bm_s2  = st_reg.bm_s1;

    // bridge mode caught once after the synchroniser has settled
    if (!st_reg.mode_done) begin
      if (st_reg.start == START_LAST) begin
        st_next.mode_done   = 1'b1;
        st_next.mode_single = st_reg.bm_s2;
      end else begin
        st_next.start = st_reg.start + 2'h1;
      end
    end

    // internal oscillator and chopping period
    tick    = (st_reg.div == DIV_LAST);
    per_end = tick && (st_reg.per == PER_LAST);
    if (tick) begin
      st_next.div = '0;
      st_next.per = st_reg.per + 4'h1;
    end else begin
      st_next.div = st_reg.div + 6'h01;
    end

    for (int b = 0; b < 2; b++) begin
      src  = st_reg.mode_single ? 0 : b;
      c    = st_reg.c_s2[src];
      stby = !st_reg.mode_done ||
             (st_reg.mode_single ? (st_reg.c_s2[0] == '0) : (st_reg.c_s2 == '0));
      act  = c.pwm && (c.in1 ^ c.in2);
      run[b] = act && !stby;

      // trip level from the reference voltage
      vsel = st_reg.mode_single ? vref_mv[0] : vref_mv[b];
      prod = {4'h0, vsel} * GAIN_NUM;
      st_next.trip[b] = st_reg.mode_single ? (prod >> SINGLE_SHIFT)
                                           : (prod >> DUAL_SHIFT);

      // blanking window after any control transition
      if (st_reg.c_s2[src] != st_reg.c_prev[src]) begin
        st_next.blank[b] = BLANK_LOAD;
      end else if (st_reg.blank[b] != '0) begin
        st_next.blank[b] = st_reg.blank[b] - 6'h01;
      end

      meas = st_reg.mode_single ? ({1'b0, isense_ma[0]} + {1'b0, isense_ma[1]})
                                : {1'b0, isense_ma[b]};
      trip_ok[b] = run[b] && (st_reg.blank[b] == '0) && (meas >= st_reg.trip[b])
                   && (st_reg.c_s2[src] == st_reg.c_prev[src]);

      // chopping sequence
      case (st_reg.phase[b])
        PH_CHARGE: begin
          if (trip_ok[b]) begin
            st_next.phase[b] = PH_FAST;
            st_next.fast[b]  = '0;
          end
        end
        PH_FAST: begin
          if (per_end) begin
            st_next.phase[b] = PH_CHARGE;
          end else if (tick) begin
            if (st_reg.fast[b] == FAST_LAST) begin
              st_next.phase[b] = PH_SLOW;
            end else begin
              st_next.fast[b] = st_reg.fast[b] + 3'h1;
            end
          end
        end
        PH_SLOW: begin
          if (per_end) begin
            st_next.phase[b] = PH_CHARGE;
          end
        end
        default: begin
          st_next.phase[b] = PH_CHARGE;
        end
      endcase
      if (!run[b]) begin
        st_next.phase[b] = PH_CHARGE;
        st_next.fast[b]  = '0;
      end

      // leg requests from drive mode and phase
      if (stby || !(c.in1 || c.in2)) begin
        want[2*b]   = GATE_OFF;
        want[2*b+1] = GATE_OFF;
      end else if (!act) begin
        want[2*b]   = GATE_LO;
        want[2*b+1] = GATE_LO;
      end else begin
        case (st_reg.phase[b])
          PH_CHARGE: begin
            want[2*b]   = c.in1 ? GATE_HI : GATE_LO;
            want[2*b+1] = c.in1 ? GATE_LO : GATE_HI;
          end
          PH_FAST: begin
            want[2*b]   = c.in1 ? GATE_LO : GATE_HI;
            want[2*b+1] = c.in1 ? GATE_HI : GATE_LO;
          end
          default: begin
            want[2*b]   = GATE_LO;
            want[2*b+1] = GATE_LO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.phase <= {PH_CHARGE, PH_CHARGE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase_out          = st_reg.phase;
  assign current_trip_level = st_reg.trip;
  assign bridge_mode_single = st_reg.mode_single;

  ////////////////////////////////////////////////////////////////////////////////
  // legs: 2b drives the plus output, 2b+1 the minus output
  for (genvar g = 0; g < 4; g++) begin : leg
    mdcs_leg #(
      .DEAD_CYC_P (DEAD_CYC_P)
    ) u_leg (
      .clk  (clk),
      .nrst (nrst),
      .want (want[g]),
      .gate (gate[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  period_step_a: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> st_reg.per == 4'($past(st_reg.per) + 4'h1))
    else $error("period counter did not advance on oscillator clock");

  period_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !tick |=> $stable(st_reg.per) && (st_reg.div == 6'($past(st_reg.div) + 6'h01)))
    else $error("period counter moved between oscillator clocks");

  mode_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.mode_done |=> st_reg.mode_done && $stable(st_reg.mode_single))
    else $error("bridge mode changed after startup");

  for (genvar b = 0; b < 2; b++) begin : chk
    phase_order_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(st_reg.phase[b]) |-> (st_reg.phase[b] == PH_CHARGE)
        || (st_reg.phase[b] == PH_FAST && $past(st_reg.phase[b]) == PH_CHARGE)
        || (st_reg.phase[b] == PH_SLOW && $past(st_reg.phase[b]) == PH_FAST))
      else $error("illegal phase order");

    charge_exit_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg.phase[b] == PH_CHARGE && trip_ok[b] && run[b]) |=> st_reg.phase[b] == PH_FAST)
      else $error("charge did not end at trip");

    fast_len_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg.phase[b] == PH_FAST && st_reg.fast[b] == FAST_LAST && tick && !per_end
       && run[b]) |=> st_reg.phase[b] == PH_SLOW)
      else $error("fast decay did not end after six clocks");

    short_fast_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg.phase[b] == PH_FAST && per_end) |=> st_reg.phase[b] == PH_CHARGE)
      else $error("fast decay did not end with the period");

    trip_lvl_a: assert property (@(posedge clk) disable iff (!nrst)
      st_reg.mode_done |=> current_trip_level[b] == (st_reg.mode_single
        ? ((17'($past(vref_mv[0])) * GAIN_NUM) >> SINGLE_SHIFT)
        : ((17'($past(vref_mv[b])) * GAIN_NUM) >> DUAL_SHIFT)))
      else $error("trip level does not match reference");

    blank_mask_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg.phase[b] == PH_CHARGE && (st_reg.blank[b] != '0
       || st_reg.c_s2[st_reg.mode_single ? 0 : b] != st_reg.c_prev[st_reg.mode_single ? 0 : b]))
      |=> st_reg.phase[b] != PH_FAST)
      else $error("trip taken inside blanking window");

    charge_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_reg.phase[b] == PH_CHARGE && !trip_ok[b]) |=> st_reg.phase[b] == PH_CHARGE)
      else $error("charge left without trip");
  end

endmodule
`default_nettype wire

// *** testbench/mdcs_winding_model.sv ***
// winding model: current of two windings driven by the bridge legs
`timescale 1ns/10ps
`default_nettype none
module mdcs_winding_model #(
  parameter int STEP_MA = 50
) (
  input  wire logic                                clk,
  input  wire logic                                nrst,
  input  wire mdcs_pkg::mdcs_gate_t [3:0]          gate,
  input  wire logic [1:0][mdcs_pkg::ISENSE_W-1:0]  bias_ma,
  output logic [1:0][mdcs_pkg::ISENSE_W-1:0]       isense_ma
);
  import mdcs_pkg::*;
  int mag [2];
  int dir [2];
  int v;
  ////////////////////////////////////////////////////////////////////////////////
  // applied polarity ramps the current up, reverse polarity decays it fast
  always @(posedge clk or negedge nrst) begin
    for (int b = 0; b < 2; b++) begin
      if (!nrst) begin
        mag[b] = 0;
        dir[b] = 0;
      end else begin
        v = 0;
        if (gate[2*b] == GATE_HI && gate[2*b+1] == GATE_LO) v = 1;
        if (gate[2*b] == GATE_LO && gate[2*b+1] == GATE_HI) v = -1;
        if (v != 0 && (mag[b] == 0 || dir[b] == v)) begin
          dir[b] = v;
          mag[b] += STEP_MA;
        end else if (v != 0) begin
          mag[b] = (mag[b] > 2 * STEP_MA) ? mag[b] - 2 * STEP_MA : 0;
        end else begin
          mag[b] = (mag[b] > STEP_MA / 4) ? mag[b] - STEP_MA / 4 : 0;
        end
      end
      isense_ma[b] <= ISENSE_W'(mag[b]) + bias_ma[b];
    end
  end
endmodule
`default_nettype wire

// *** testbench/mdcs_top_tb_top.sv ***
// self-checking bench for the mixed decay chop sequencer
`timescale 1ns/10ps
`default_nettype none
module mdcs_top_tb_top;
  import mdcs_pkg::*;
  localparam int OSC      = 2;
  localparam int BLK      = 8;
  localparam int DEAD     = 2;
  localparam int PER_CYC  = CHOP_CLKS * OSC;
  localparam int FAST_CYC = FAST_CLKS * OSC;
  logic                     clk = 1'b0;
  logic                     nrst = 1'b0;
  mdcs_ctrl_t [1:0]         ctrl_pin = '0;
  logic                     bms = 1'b0;
  logic [1:0][VREF_W-1:0]   vref_mv = '0;
  logic [1:0][ISENSE_W-1:0] bias_ma = '0;
  logic [1:0][ISENSE_W-1:0] isense_ma;
  mdcs_gate_t [3:0]         gate;
  logic [1:0][2:0]          phase_out;
  logic [1:0][TRIP_W-1:0]   trip;
  logic                     mode_single;
  logic                     mon_on = 1'b0;
  logic [2:0]               ph_q;
  mdcs_gate_t               last_on [4];
  int                       off_cnt [4];
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_fast, t_pe, t_chg, max_chg, max_i, bad;
  always #12.5 clk = ~clk;
  mdcs_top #(.OSC_DIV_P(OSC), .BLANK_CYC_P(BLK), .DEAD_CYC_P(DEAD)) dut (
    .clk(clk), .nrst(nrst), .ctrl_pin(ctrl_pin), .bridge_mode_select(bms),
    .vref_mv(vref_mv), .isense_ma(isense_ma), .gate(gate), .phase_out(phase_out),
    .current_trip_level(trip), .bridge_mode_single(mode_single));
  mdcs_winding_model wind (
    .clk(clk), .nrst(nrst), .gate(gate), .bias_ma(bias_ma), .isense_ma(isense_ma));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // dead time watched on every edge, phase order and period alignment only while mon_on is set
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      failures++;
      tally_and_finish();
    end
    if (!nrst) begin
      ph_q = PH_CHARGE;
      t_pe = -1;
      for (int l = 0; l < 4; l++) begin
        off_cnt[l] = 0;
        last_on[l] = GATE_OFF;
      end
    end else begin
      for (int l = 0; l < 4; l++) begin
        if (gate[l] == GATE_OFF) begin
          off_cnt[l]++;
        end else begin
          if (last_on[l] != GATE_OFF && gate[l] != last_on[l])
            chk("dead_time", off_cnt[l] >= DEAD, 1);
          last_on[l] = gate[l];
          off_cnt[l] = 0;
        end
      end
      if (mon_on && phase_out[0] != ph_q) begin
        if (phase_out[0] == PH_FAST) begin
          chk("trip_reached", isense_ma[0] >= trip[0], 1);
          chk("enter_fast", ph_q, PH_CHARGE);
          t_fast = cyc;
        end
        if (phase_out[0] == PH_SLOW) begin
          chk("fast_to_slow", ph_q, PH_FAST);
          chk("fast_len", (cyc - t_fast) inside {[FAST_CYC - OSC:FAST_CYC]}, 1);
        end
        if (phase_out[0] == PH_CHARGE) begin
          if (ph_q == PH_FAST) chk("fast_cut", cyc - t_fast <= FAST_CYC, 1);
          if (t_pe >= 0) chk("period_end", (cyc - t_pe) % PER_CYC, 0);
          t_pe = cyc;
          t_chg = cyc;
        end
      end
      if (mon_on && phase_out[0] == PH_CHARGE && cyc - t_chg > max_chg) max_chg = cyc - t_chg;
      if (mon_on && isense_ma[0] > max_i) max_i = isense_ma[0];
      ph_q = phase_out[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_dut(input logic mode);
    @(posedge clk);
    nrst <= 1'b0;
    bms <= mode;
    ctrl_pin <= '0;
    repeat (3) @(posedge clk);
    chk("rst_gate", gate, 0);
    chk("rst_phase", phase_out, 6'h09);
    chk("rst_trip", trip == '0, 1);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_trip(input logic mode);
    @(posedge clk);
    vref_mv <= {13'h0bb8, 13'h07d0};
    repeat (3) @(posedge clk);
    chk("mode", mode_single, mode);
    chk("trip_a", trip[0], mode ? 4500 : 2250);
    if (!mode) chk("trip_b", trip[1], 3375);
  endtask
  task automatic t_chop();
    @(posedge clk);
    t_pe = -1;
    t_chg = cyc;
    max_chg = 0;
    max_i = 0;
    mon_on <= 1'b1;
    ctrl_pin[0] <= 3'h5;
    repeat (600) @(posedge clk);
    // reverse only at a fresh period start so the old current decays under blanking
    for (int k = 0; k < PER_CYC && phase_out[0] == PH_CHARGE; k++) @(posedge clk);
    for (int k = 0; k < PER_CYC && phase_out[0] != PH_CHARGE; k++) @(posedge clk);
    ctrl_pin[0] <= 3'h3;
    repeat (400) @(posedge clk);
    chk("b_idle", {gate[3], gate[2]}, 0);
    chk("long_charge", max_chg > PER_CYC, 1);
    chk("peak", max_i <= 2250 + 150, 1);
    mon_on <= 1'b0;
    ctrl_pin[0] <= 3'h0;
    repeat (100) @(posedge clk);
  endtask
  task automatic t_blank();
    @(posedge clk);
    bias_ma[0] <= 16'h1388;
    repeat (4) @(posedge clk);
    ctrl_pin[0] <= 3'h5;
    for (int k = 0; k < BLK; k++) begin
      @(posedge clk);
      chk("blanked", phase_out[0], PH_CHARGE);
    end
    bad = 1;
    for (int k = 0; k < 30 && bad == 1; k++) begin
      @(posedge clk);
      if (phase_out[0] == PH_FAST) bad = 0;
    end
    chk("trip_after_blank", bad, 0);
    ctrl_pin[0] <= 3'h6;
    repeat (10) @(posedge clk);
    chk("brake_gate", {gate[1], gate[0]}, 4'h5);
    chk("brake_phase", phase_out[0], PH_CHARGE);
    ctrl_pin[0] <= 3'h1;
    repeat (6) @(posedge clk);
    chk("stop_gate", {gate[1], gate[0]}, 0);
    bias_ma[0] <= '0;
    ctrl_pin[0] <= 3'h0;
  endtask
  task automatic t_single();
    @(posedge clk);
    ctrl_pin[0] <= 3'h5;
    bms <= 1'b0;
    bad = 0;
    repeat (300) begin
      @(posedge clk);
      if (phase_out[1] !== phase_out[0] || {gate[3], gate[2]} !== {gate[1], gate[0]}) bad++;
    end
    chk("lockstep", bad, 0);
    chk("mode_latched", mode_single, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_dut(1'b0);
    t_trip(1'b0);
    t_chop();
    t_blank();
    reset_dut(1'b1);
    t_trip(1'b1);
    t_single();
    tally_and_finish();
  end
endmodule
`default_nettype wire
